// ### verilog/sbs_port.sv
`timescale 1ns/1ns
module sbs_port (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // address and burst control
  input wire logic [sbs_pkg::UPPER_W-1:0] addrIn,
  input wire logic [sbs_pkg::LSB_W-1:0] burstAddrLsbs,
  input wire logic procAddrStrobe_n,
  input wire logic ctrlAddrStrobe_n,
  input wire logic burstStep_n,
  input wire logic chipEnPrimary_n,
  input wire logic depthEnHigh,
  // write selects
  input wire logic [sbs_pkg::LANES-1:0] byteWriteSel_n,
  input wire logic globalWrite_n,
  input wire logic laneWrite_n,
  // unregistered controls
  input wire logic outEnable_n,
  input wire logic burstOrderSel,
  input wire logic sleepReq,
  // data pins
  input wire logic [sbs_pkg::DATA_W-1:0] byteLaneDataIn,
  output logic [sbs_pkg::DATA_W-1:0] byteLaneDataOut,
  output logic byteLaneDataOe,
  // status
  output logic writeBufReady
);
  import sbs_pkg::*;

  logic [DATA_W-1:0] mem [0:DEPTH-1];
  sbs_state_t state_r;
  sbs_state_t state_nxt;
  logic [UPPER_W-1:0] upper_r;
  logic [LSB_W-1:0] start_r;
  logic [LSB_W-1:0] beat_r;
  logic [LSB_W-1:0] beat_nxt;
  logic readValid_r;
  logic lowPower_r;
  logic [DATA_W-1:0] dataOut_r;
  logic bufReady_r;
  logic bufInReady;
  logic headValid;
  logic tailValid;
  logic [$bits(sbs_wr_t)-1:0] headBits;
  logic [$bits(sbs_wr_t)-1:0] tailBits;
  sbs_wr_t headEnt;
  sbs_wr_t tailEnt;
  sbs_wr_t newEnt;

  // the core, all but lowPower_r and bufReady_r, holds while asleep, as if its clock were stopped
  wire awake = !sleepReq;
  wire chipSel = !chipEnPrimary_n && depthEnHigh;
  wire procStart = !procAddrStrobe_n && !chipEnPrimary_n;
  wire newCycle = procStart || !ctrlAddrStrobe_n;
  wire startSel = newCycle && chipSel;
  wire contCycle = !newCycle && (state_r == ST_BURST);
  wire advance = contCycle && !burstStep_n;
  // global write overrides, otherwise lane write gates byte selects
  wire [LANES-1:0] wrMask = !globalWrite_n ? MASK_ALL : (!laneWrite_n ? ~byteWriteSel_n : MASK_NONE);
  wire isWrite = (wrMask != MASK_NONE);
  // a processor strobe that selects the chip always begins a read
  wire doWrite = awake && isWrite && ((startSel && !procStart) || contCycle);
  wire doRead = awake && !isWrite && (startSel || contCycle) || awake && procStart && startSel;
  wire [LSB_W-1:0] curBeat = startSel ? BEAT_FIRST : beat_nxt;
  wire [LSB_W-1:0] curStart = startSel ? burstAddrLsbs : start_r;
  wire [UPPER_W-1:0] curUpper = startSel ? addrIn : upper_r;
  // order input is read live, never latched
  wire [LSB_W-1:0] curLsbs = burstOrderSel ? (curStart ^ curBeat) : (curStart + curBeat);
  wire [ADDR_W-1:0] curAddr = {curUpper, curLsbs};

  assign beat_nxt = advance ? beat_r + BEAT_STEP : beat_r;
  assign headEnt = sbs_wr_t'(headBits);
  assign tailEnt = sbs_wr_t'(tailBits);
  assign newEnt = '{addr: curAddr, data: byteLaneDataIn, mask: wrMask};

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] w, input sbs_wr_t e, input logic v,
                                              input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] r;
    r = w;
    if (v && e.addr == a) begin
      for (int i = 0; i < LANES; i++) begin
        if (e.mask[i]) r[i*LANE_W +: LANE_W] = e.data[i*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction

  // pending writes are forwarded, older entry first so the newer wins
  wire [DATA_W-1:0] readWord = merge(merge(mem[curAddr], headEnt, headValid, curAddr), tailEnt, tailValid, curAddr);
  // the array port is shared: a read stalls the drain, as does sleep
  wire drainReady = awake && !doRead;

  sbs_buf2 #(.W($bits(sbs_wr_t))) wrBuf (
    .mclk(mclk),
    .rst(rst),
    .inValid(doWrite),
    .inReady(bufInReady),
    .inData(newEnt),
    .outValid(headValid),
    .outReady(drainReady),
    .outData(headBits),
    .tailValid(tailValid),
    .tailData(tailBits)
  );

  always_comb begin
    state_nxt = state_r;
    if (newCycle) state_nxt = chipSel ? ST_BURST : ST_DESEL;
  end

  always_ff @(posedge mclk) begin
    if (headValid && drainReady) begin
      for (int i = 0; i < LANES; i++) begin
        if (headEnt.mask[i]) mem[headEnt.addr][i*LANE_W +: LANE_W] <= headEnt.data[i*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_DESEL;
      upper_r <= '0;
      start_r <= '0;
      beat_r <= '0;
    end else if (awake) begin
      state_r <= state_nxt;
      if (startSel) begin
        upper_r <= addrIn;
        start_r <= burstAddrLsbs;
      end
      beat_r <= curBeat;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readValid_r <= 1'b0;
      dataOut_r <= '0;
      lowPower_r <= 1'b0;
      bufReady_r <= 1'b1;
    end else begin
      bufReady_r <= bufInReady;
      if (sleepReq) lowPower_r <= 1'b1;
      else if (doRead || doWrite) lowPower_r <= 1'b0;
      if (awake) begin
        readValid_r <= doRead;
        if (doRead) dataOut_r <= readWord;
      end
    end
  end

  assign byteLaneDataOut = dataOut_r;
  // enable is combinational so the pins follow output enable at once
  assign byteLaneDataOe = readValid_r && !outEnable_n && !sleepReq && !lowPower_r;
  assign writeBufReady = bufReady_r;

  AST_DESEL_ON_CTRL: assert property (@(posedge mclk) disable iff (rst)
    (awake && !ctrlAddrStrobe_n && chipEnPrimary_n) |=> state_r == ST_DESEL)
    else $error("controller strobe with enable high did not deselect");
  AST_PROC_BLOCKED: assert property (@(posedge mclk) disable iff (rst)
    (awake && !procAddrStrobe_n && chipEnPrimary_n && ctrlAddrStrobe_n) |=> $stable(state_r))
    else $error("blocked processor strobe changed state");
  AST_DEPTH_GATE: assert property (@(posedge mclk) disable iff (rst)
    (awake && newCycle && !depthEnHigh) |=> state_r == ST_DESEL && !readValid_r)
    else $error("depth enable low still selected");
  AST_NEW_ADDR: assert property (@(posedge mclk) disable iff (rst)
    (awake && startSel) |=> upper_r == $past(addrIn) && start_r == $past(burstAddrLsbs) && beat_r == BEAT_FIRST)
    else $error("new address not captured");
  AST_BEAT_STEP: assert property (@(posedge mclk) disable iff (rst)
    (awake && advance) |=> beat_r == $past(beat_r) + BEAT_STEP)
    else $error("burst counter did not step");
  AST_BEAT_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (awake && contCycle && burstStep_n) |=> $stable(beat_r))
    else $error("burst counter moved while suspended");
  AST_LINEAR: assert property (@(posedge mclk) disable iff (rst)
    (!burstOrderSel && contCycle) |-> curLsbs == LSB_W'(start_r + beat_nxt))
    else $error("linear burst address wrong");
  AST_INTERLEAVE: assert property (@(posedge mclk) disable iff (rst)
    (burstOrderSel && contCycle) |-> curLsbs == (start_r ^ beat_nxt))
    else $error("interleaved burst address wrong");
  AST_GLOBAL_ALL: assert property (@(posedge mclk) disable iff (rst)
    !globalWrite_n |-> wrMask == MASK_ALL)
    else $error("global write missed a lane");
  AST_LANE_ONLY: assert property (@(posedge mclk) disable iff (rst)
    (globalWrite_n && !laneWrite_n) |-> wrMask == ~byteWriteSel_n)
    else $error("lane write mask wrong");
  AST_READ_FLOW: assert property (@(posedge mclk) disable iff (rst)
    (doRead && !tailValid && !headValid) |=> readValid_r && byteLaneDataOut == $past(mem[curAddr]))
    else $error("read data not presented next cycle");
  AST_OE_FLOAT: assert property (@(posedge mclk) disable iff (rst)
    (outEnable_n || sleepReq) |-> !byteLaneDataOe)
    else $error("pins driven while disabled");
  AST_SLEEP_HOLD: assert property (@(posedge mclk) disable iff (rst)
    sleepReq |=> $stable(state_r) && $stable(beat_r) && lowPower_r)
    else $error("core moved during sleep");

  COV_BURST_READ: cover property (@(posedge mclk) disable iff (rst) startSel && doRead ##1 advance [*3]);
  COV_BURST_WRITE: cover property (@(posedge mclk) disable iff (rst) doWrite && startSel ##1 doWrite && advance);
  COV_BUF_FULL: cover property (@(posedge mclk) disable iff (rst) !bufInReady);
  COV_SLEEP_WAKE: cover property (@(posedge mclk) disable iff (rst) sleepReq ##1 !sleepReq ##[1:20] doRead);
endmodule // sbs_port

// ### pkg/sbs_pkg.sv
// Operation
// - controller strobe aborts burst, loads address, starts
// - processor strobe loads address, blocked by chip enable
// - advance low steps burst address each clock
// - output enable drives or floats data asynchronously
// - address, data, controls registered on rising edge
// - burst order static, unlatched: linear or interleaved
// - global write low writes all lanes
// - lane write writes only selected byte lanes
// - primary enable high blocks processor, deselects controller
// - depth enable high required for selection
// - data split into byte lanes a, b
// - linear order adds beat modulo four
// - write when global low or lane+byte low
// - sleep stops clock, floats; low power until access
package sbs_pkg;
  localparam int LSB_W = 2;
  localparam int UPPER_W = 17;
  localparam int ADDR_W = UPPER_W + LSB_W;
  localparam int LANES = 2;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [LANES-1:0] MASK_ALL = 2'h3;
  localparam logic [LANES-1:0] MASK_NONE = 2'h0;
  localparam logic [LSB_W-1:0] BEAT_FIRST = 2'h0;
  localparam logic [LSB_W-1:0] BEAT_STEP = 2'h1;

  typedef enum logic {ST_DESEL, ST_BURST} sbs_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] mask;
  } sbs_wr_t;
endpackage

// ### verilog/sbs_buf2.sv
`timescale 1ns/1ns
module sbs_buf2 #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData,
  // second entry, visible for forwarding
  output logic tailValid,
  output logic [W-1:0] tailData
);
  logic [1:0] cnt_r;
  logic [W-1:0] head_r;
  logic [W-1:0] tail_r;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  assign inReady = (cnt_r != 2'h2);
  assign outValid = (cnt_r != 2'h0);
  assign tailValid = (cnt_r == 2'h2);
  assign outData = head_r;
  assign tailData = tail_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 2'h0;
      head_r <= '0;
      tail_r <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_r == 2'h0) head_r <= inData;
          else tail_r <= inData;
          cnt_r <= cnt_r + 2'h1;
        end
        2'b01: begin
          head_r <= tail_r;
          cnt_r <= cnt_r - 2'h1;
        end
        2'b11: begin
          if (cnt_r == 2'h1) begin
            head_r <= inData;
          end else begin
            head_r <= tail_r;
            tail_r <= inData;
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule // sbs_buf2

// ### verif/sbs_host_model.sv
`timescale 1ns/1ns
module sbs_host_model (
  // host side
  input wire logic mclk,
  input wire logic [sbs_pkg::ADDR_W-1:0] hostAddr,
  input wire logic [sbs_pkg::DATA_W-1:0] hostData,
  input wire logic hostOe,
  // device side
  input wire logic [sbs_pkg::DATA_W-1:0] devData,
  input wire logic devOe,
  output logic [sbs_pkg::UPPER_W-1:0] addrUpper,
  output logic [sbs_pkg::LSB_W-1:0] addrLsbs,
  output logic [sbs_pkg::DATA_W-1:0] busLevel
);
  import sbs_pkg::*;
  logic [DATA_W-1:0] last_r = '0;
  // the bus's two lowest bits feed the burst counter inputs
  assign addrUpper = hostAddr[ADDR_W-1:LSB_W];
  assign addrLsbs = hostAddr[LSB_W-1:0];
  // a released bus toggles every cycle so a stale word never passes as written data
  assign busLevel = (hostOe && devOe) ? 'x : hostOe ? hostData : devOe ? devData : ~last_r;
  always @(posedge mclk) begin
    last_r <= busLevel;
  end
endmodule // sbs_host_model

// ### verif/sbs_port_tb.sv
`timescale 1ns/1ns
module sbs_port_tb;
  import sbs_pkg::*;
  // {ctrl strobe, proc strobe, step, global write}, all active low
  localparam logic [3:0] CW = 4'h6, CWS = 4'hc, CR = 4'h7, PR = 4'hb, ST = 4'hd, ID = 4'hf, PRS = 4'h9;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] ctl = 4'hf;
  logic [ADDR_W-1:0] hAddr = '0;
  logic [DATA_W-1:0] hData = '0;
  logic hOe = 1'b0;
  logic ce_n = 1'b0, de = 1'b1, lw_n = 1'b1, ord = 1'b0, slp = 1'b0, oe_n = 1'b0;
  logic [LANES-1:0] bws_n = 2'h3;
  logic ceV = 1'b0, deV = 1'b1, lwV = 1'b1, ordV = 1'b0, slpV = 1'b0;
  logic [LANES-1:0] bwsV = 2'h3;
  logic [UPPER_W-1:0] upper;
  logic [LSB_W-1:0] lsbs;
  logic [DATA_W-1:0] bus, dOut, pData;
  logic dOe, wbReady, pOe;
  bit pend = 0;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  always #5 mclk = ~mclk;
  sbs_host_model u_host (.mclk(mclk), .hostAddr(hAddr), .hostData(hData), .hostOe(hOe), .devData(dOut),
    .devOe(dOe), .addrUpper(upper), .addrLsbs(lsbs), .busLevel(bus));
  // no scan pins on this port: the board keeps the test clock on a rail
  sbs_port u_dut (.mclk(mclk), .rst(rst), .addrIn(upper), .burstAddrLsbs(lsbs), .procAddrStrobe_n(ctl[2]),
    .ctrlAddrStrobe_n(ctl[3]), .burstStep_n(ctl[1]), .chipEnPrimary_n(ce_n), .depthEnHigh(de),
    .byteWriteSel_n(bws_n), .globalWrite_n(ctl[0]), .laneWrite_n(lw_n), .outEnable_n(oe_n),
    .burstOrderSel(ord), .sleepReq(slp), .byteLaneDataIn(bus), .byteLaneDataOut(dOut),
    .byteLaneDataOe(dOe), .writeBufReady(wbReady));
  task automatic chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one cycle per call; the answer of the previous call is checked once this edge has settled
  task automatic op(input logic [3:0] c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic eo, input logic [DATA_W-1:0] ed);
    logic wr;
    wr = !c[0] || (!lwV && bwsV != 2'h3);
    @(posedge mclk);
    ctl <= c;
    hAddr <= a;
    hData <= d;
    hOe <= wr;
    // output enable is lifted for a write so the read just before it cannot clash with the host's data
    oe_n <= wr;
    ce_n <= ceV;
    de <= deV;
    lw_n <= lwV;
    bws_n <= bwsV;
    ord <= ordV;
    slp <= slpV;
    @(negedge mclk);
    if (pend) begin
      chk("oe", DATA_W'(dOe), DATA_W'(pOe && !wr && !slpV));
      if (pOe) begin
        chk("data", dOut, pData);
      end
    end
    if (wr) begin
      chk("wrBus", bus, hData);
    end
    pend = 1;
    pOe = eo;
    pData = ed;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 500) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    chk("rstOe", DATA_W'(dOe), '0);
    rst <= 1'b0;
    op(CW, 19'h00100, 18'h000a0, 0, '0);
    op(CWS, 19'h00100, 18'h000a1, 0, '0);
    op(CWS, 19'h00100, 18'h000a2, 0, '0);
    op(CWS, 19'h00100, 18'h000a3, 0, '0);
    op(CR, 19'h00101, '0, 1, 18'h000a1);
    op(ST, 19'h00100, '0, 1, 18'h000a2);
    op(ST, 19'h00100, '0, 1, 18'h000a3);
    op(ST, 19'h00100, '0, 1, 18'h000a0);
    ordV = 1'b1; // held static across the burst
    op(PR, 19'h00101, '0, 1, 18'h000a1);
    op(ST, 19'h00100, '0, 1, 18'h000a0);
    op(ST, 19'h00100, '0, 1, 18'h000a3);
    op(ST, 19'h00100, '0, 1, 18'h000a2);
    op(CR, 19'h00102, '0, 1, 18'h000a2);
    ceV = 1'b1;
    op(PRS, 19'h00103, '0, 1, 18'h000a3);
    op(CR, 19'h00100, '0, 0, '0);
    ceV = 1'b0;
    deV = 1'b0;
    op(CR, 19'h00100, '0, 0, '0);
    deV = 1'b1;
    ordV = 1'b0;
    lwV = 1'b0; // byte-only write: lane write held low
    bwsV = 2'h1;
    op(CR, 19'h00100, 18'h3ffff, 0, '0);
    bwsV = 2'h3;
    op(CR, 19'h00100, '0, 1, 18'h3fea0);
    op(CW, 19'h00101, 18'h12345, 0, '0);
    op(CR, 19'h00101, '0, 1, 18'h12345);
    op(ID, 19'h00101, '0, 1, 18'h12345);
    @(posedge mclk);
    oe_n <= 1'b1;
    #1;
    chk("oeAsync", DATA_W'(dOe), '0);
    @(posedge mclk);
    oe_n <= 1'b0;
    op(CW, 19'h00102, 18'h2aaaa, 0, '0);
    op(CR, 19'h00102, '0, 1, 18'h2aaaa);
    slpV = 1'b1;
    op(CR, 19'h00101, '0, 0, '0);
    slpV = 1'b0;
    op(ID, 19'h00101, '0, 1, 18'h2aaaa);
    op(ID, 19'h00102, '0, 1, 18'h2aaaa);
    chk("bufReady", DATA_W'(wbReady), 18'h00001);
    wrap_up();
  end
endmodule // sbs_port_tb
